// [hw/vco_autocal_pkg.sv]
`default_nettype none

package vco_autocal_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map. Printed offsets are register indices; byte address is
  // four times the index.

  localparam int unsigned num_regs = 10;
  localparam int unsigned reg_w    = 8;
  localparam int unsigned addr_w   = 12;

  localparam logic [7:0] idx_level_control_disable        = 8'h2c;
  localparam logic [7:0] idx_band_select_divider          = 8'h30;
  localparam logic [7:0] idx_calibration_timeout_low      = 8'h31;
  localparam logic [7:0] idx_adc_control_timeout_high     = 8'h32;
  localparam logic [7:0] idx_readback_select_lock_timeout = 8'h33;
  localparam logic [7:0] idx_calibration_test_mode        = 8'h34;
  localparam logic [7:0] idx_adc_clock_divider            = 8'h35;
  localparam logic [7:0] idx_pump_offset_reserved         = 8'h36;
  localparam logic [7:0] idx_manual_band_value            = 8'h37;
  localparam logic [7:0] idx_manual_core_value            = 8'h38;

  // Slot order of the storage array, slot 0 in the low byte.
  localparam logic [num_regs-1:0][7:0] slot_index = {
    idx_manual_core_value,
    idx_manual_band_value,
    idx_pump_offset_reserved,
    idx_adc_clock_divider,
    idx_calibration_test_mode,
    idx_readback_select_lock_timeout,
    idx_adc_control_timeout_high,
    idx_calibration_timeout_low,
    idx_band_select_divider,
    idx_level_control_disable
  };

  localparam logic [3:0] slot_level  = 4'h0;
  localparam logic [3:0] slot_bdiv   = 4'h1;
  localparam logic [3:0] slot_tlow   = 4'h2;
  localparam logic [3:0] slot_adcctl = 4'h3;
  localparam logic [3:0] slot_rbsel  = 4'h4;
  localparam logic [3:0] slot_tmode  = 4'h5;
  localparam logic [3:0] slot_adcdiv = 4'h6;
  localparam logic [3:0] slot_pump   = 4'h7;
  localparam logic [3:0] slot_mband  = 4'h8;
  localparam logic [3:0] slot_mcore  = 4'h9;

  localparam logic [7:0] reg_reset = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.

  localparam int unsigned pos_level_ctl_off      = 0;
  localparam int unsigned pos_adc_input_select   = 7;
  localparam int unsigned pos_adc_quick_convert  = 5;
  localparam int unsigned pos_adc_repeat_convert = 4;
  localparam int unsigned pos_adc_convert        = 3;
  localparam int unsigned pos_adc_enable         = 2;
  localparam int unsigned pos_timeout_high_msb   = 1;
  localparam int unsigned pos_select_msb         = 7;
  localparam int unsigned pos_select_lsb         = 5;
  localparam int unsigned pos_limit_msb          = 4;
  localparam int unsigned pos_core_msb           = 7;
  localparam int unsigned pos_core_lsb           = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings.

  localparam logic [2:0] readback_checker   = 3'b000;
  localparam logic [2:0] readback_core_band = 3'b001;
  localparam logic [2:0] readback_adc       = 3'b101;
  localparam logic [15:0] checker_pattern   = 16'haa55;

  localparam logic [2:0] mode_normal        = 3'b000;
  localparam logic [2:0] mode_manual_core   = 3'b010;
  localparam logic [2:0] mode_manual_volt   = 3'b100;

  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic {w_idle, w_resp} write_state_t;
  typedef enum logic {r_idle, r_resp} read_state_t;

endpackage : vco_autocal_pkg

`default_nettype wire

// [hw/vco_autocal_control_regs.sv]
// Local design decision: register access over AXI4-Lite.
`default_nettype none

// Operation
// RULE1: Level-control bit 0 disables oscillator automatic level control when set.
// RULE2: Band-select divider divides phase detector ticks into band-select clock ticks.
// RULE3: Calibration timeout is ten bits: low byte plus ADC control bits 1:0.
// RULE4: ADC input select picks temperature voltage at 0, tuning voltage at 1.
// RULE5: ADC enable bit 2 powers the ADC; bit 3 requests a conversion.
// RULE6: Bit 5 enables quick conversion, bit 4 repeated back-to-back conversion.
// RULE7: Five-bit lock wait limit in bits 4:0 sets the lock wait.
// RULE8: Readback select picks checkerboard, core and band, or ADC result.
// RULE9: Three-bit test mode selects normal, manual core/band or manual voltage.
// RULE10: Software keeps the level wait limit field at zero.
// RULE11: ADC clock is phase detector rate over four times divider plus two.
// RULE12: Manual band value supplies the band when calibration is bypassed.
// RULE13: Manual core in bits 7:4 supplies the core when bypassed.
// RULE14: All registers are eight-bit, read/write, and reset to zero.
// RULE15: Manual core and band apply only in manual core/band test mode.
module vco_autocal_control_regs #(
  parameter int unsigned adc_result_w = 8
) (
  input  wire  logic                                 aclk,
  input  wire  logic                                 aresetn,
  input  wire  logic [vco_autocal_pkg::addr_w-1:0]   s_axi_awaddr,
  input  wire  logic [2:0]                           s_axi_awprot,
  input  wire  logic                                 s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire  logic [31:0]                          s_axi_wdata,
  input  wire  logic [3:0]                           s_axi_wstrb,
  input  wire  logic                                 s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire  logic                                 s_axi_bready,
  input  wire  logic [vco_autocal_pkg::addr_w-1:0]   s_axi_araddr,
  input  wire  logic [2:0]                           s_axi_arprot,
  input  wire  logic                                 s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire  logic                                 s_axi_rready,
  input  wire  logic                                 phase_detector_tick,
  input  wire  logic [3:0]                           cal_core,
  input  wire  logic [7:0]                           cal_band,
  input  wire  logic [adc_result_w-1:0]              adc_result,
  output logic                                       level_ctl_off,
  output logic                                       band_clk_tick,
  output logic [9:0]                                 cal_timeout,
  output logic                                       adc_input_select,
  output logic                                       adc_enable,
  output logic                                       adc_convert,
  output logic                                       adc_quick_convert,
  output logic                                       adc_repeat_convert,
  output logic                                       adc_clk_tick,
  output logic [4:0]                                 lock_wait_limit,
  output logic [4:0]                                 level_wait_limit,
  output logic [2:0]                                 cal_test_mode,
  output logic                                       manual_core_band_mode,
  output logic                                       manual_voltage_mode,
  output logic [7:0]                                 pump_offset_trim,
  output logic [3:0]                                 core_select,
  output logic [7:0]                                 band_select,
  output logic [15:0]                                cal_readback
);

  import vco_autocal_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    write_state_t                  wstate;
    logic                          aw_held;
    logic [addr_w-1:0]             aw_addr;
    logic                          w_held;
    logic [7:0]                    w_data;
    logic                          w_lane0;
    logic [1:0]                    bresp;
    read_state_t                   rstate;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic [num_regs-1:0][reg_w-1:0] regs;
    logic [7:0]                    band_count;
    logic                          band_tick;
    logic [9:0]                    adc_count;
    logic                          adc_tick;
    logic [3:0]                    core_out;
    logic [7:0]                    band_out;
    logic [15:0]                   readback;
  } state_t;

  state_t state;
  state_t next_state;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths.

  function automatic logic [4:0] decode_slot(input logic [addr_w-1:0] addr);
    logic [4:0] result;
    result = 5'h00;
    for (int unsigned i = 0; i < num_regs; i++) begin
      if (addr[1:0] == 2'b00 &&
          addr[addr_w-1:2] == {2'b00, slot_index[i]}) begin
        result = {1'b1, 4'(i)};
      end
    end
    return result;
  endfunction : decode_slot

  logic [4:0] write_hit;
  logic [4:0] read_hit;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;

  assign write_hit = decode_slot(state.aw_addr);
  assign read_hit  = decode_slot(s_axi_araddr);

  // Address and data are latched independently, so they may arrive in
  // either order; neither is taken again until the response is accepted.
  assign s_axi_awready = state.wstate == w_idle && !state.aw_held;
  assign s_axi_wready  = state.wstate == w_idle && !state.w_held;
  assign s_axi_bvalid  = state.wstate == w_resp;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = state.rstate == r_idle;
  assign s_axi_rvalid  = state.rstate == r_resp;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_state = state;
    next_state.band_tick = 1'b0;
    next_state.adc_tick  = 1'b0;

    if (aw_take) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_state.w_held  = 1'b1;
      next_state.w_data  = s_axi_wdata[7:0];
      next_state.w_lane0 = s_axi_wstrb[0];
    end

    case (state.wstate)
      w_idle: begin
        if (state.aw_held && state.w_held) begin
          next_state.wstate = w_resp;
          if (write_hit[4]) begin
            next_state.bresp = resp_okay;
            // Only byte lane 0 carries register data; upper lanes are
            // ignored since every register is eight bits wide.
            if (state.w_lane0) begin
              next_state.regs[write_hit[3:0]] = state.w_data; // RULE14
            end
          end else begin
            next_state.bresp = resp_slverr;
          end
        end
      end
      w_resp: begin
        if (s_axi_bready) begin
          next_state.wstate  = w_idle;
          next_state.aw_held = 1'b0;
          next_state.w_held  = 1'b0;
        end
      end
      default: begin
        next_state.wstate = w_idle;
      end
    endcase

    case (state.rstate)
      r_idle: begin
        if (ar_take) begin
          next_state.rstate = r_resp;
          if (read_hit[4]) begin
            next_state.rdata = {24'h000000, state.regs[read_hit[3:0]]}; // RULE14
            next_state.rresp = resp_okay;
          end else begin
            next_state.rdata = 32'h00000000;
            next_state.rresp = resp_slverr;
          end
        end
      end
      r_resp: begin
        if (s_axi_rready) begin
          next_state.rstate = r_idle;
        end
      end
      default: begin
        next_state.rstate = r_idle;
      end
    endcase

    // A divider of zero stops the band-select clock rather than wrapping.
    if (phase_detector_tick && state.regs[slot_bdiv] != 8'h00) begin
      if (state.band_count == state.regs[slot_bdiv] - 8'h01) begin // RULE2
        next_state.band_count = 8'h00;
        next_state.band_tick  = 1'b1;
      end else begin
        next_state.band_count = state.band_count + 8'h01;
      end
    end

    // Period is four times the divider plus two phase detector ticks.
    if (!state.regs[slot_adcctl][pos_adc_enable]) begin
      next_state.adc_count = 10'h000;
    end else if (phase_detector_tick) begin
      if (state.adc_count == {state.regs[slot_adcdiv], 2'b01}) begin // RULE11
        next_state.adc_count = 10'h000;
        next_state.adc_tick  = 1'b1;
      end else begin
        next_state.adc_count = state.adc_count + 10'h001;
      end
    end

    // Manual values override the calibration result only in their mode.
    if (state.regs[slot_tmode][pos_select_msb:pos_select_lsb]
        == mode_manual_core) begin // RULE15 RULE9
      next_state.core_out =
        state.regs[slot_mcore][pos_core_msb:pos_core_lsb]; // RULE13
      next_state.band_out = state.regs[slot_mband]; // RULE12
    end else begin
      next_state.core_out = cal_core;
      next_state.band_out = cal_band;
    end

    case (state.regs[slot_rbsel][pos_select_msb:pos_select_lsb]) // RULE8
      readback_checker: begin
        next_state.readback = checker_pattern;
      end
      readback_core_band: begin
        next_state.readback = {4'h0, state.core_out, state.band_out};
      end
      readback_adc: begin
        next_state.readback = 16'(adc_result);
      end
      default: begin
        next_state.readback = 16'h0000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state            <= '0;
      state.wstate     <= w_idle;
      state.rstate     <= r_idle;
      for (int unsigned i = 0; i < num_regs; i++) begin
        state.regs[i] <= reg_reset; // RULE14
      end
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field outputs, straight from the register flops.

  assign level_ctl_off = state.regs[slot_level][pos_level_ctl_off]; // RULE1
  assign band_clk_tick = state.band_tick; // RULE2
  assign cal_timeout   = {state.regs[slot_adcctl][pos_timeout_high_msb:0],
                          state.regs[slot_tlow]}; // RULE3
  assign adc_input_select =
    state.regs[slot_adcctl][pos_adc_input_select]; // RULE4
  assign adc_enable  = state.regs[slot_adcctl][pos_adc_enable]; // RULE5
  assign adc_convert = state.regs[slot_adcctl][pos_adc_convert]; // RULE5
  assign adc_quick_convert =
    state.regs[slot_adcctl][pos_adc_quick_convert]; // RULE6
  assign adc_repeat_convert =
    state.regs[slot_adcctl][pos_adc_repeat_convert]; // RULE6
  assign adc_clk_tick = state.adc_tick; // RULE11
  assign lock_wait_limit =
    state.regs[slot_rbsel][pos_limit_msb:0]; // RULE7
  // Software is expected to leave this at zero; it is passed on as is.
  assign level_wait_limit = state.regs[slot_tmode][pos_limit_msb:0];
  assign cal_test_mode =
    state.regs[slot_tmode][pos_select_msb:pos_select_lsb]; // RULE9
  assign manual_core_band_mode = cal_test_mode == mode_manual_core; // RULE9
  assign manual_voltage_mode   = cal_test_mode == mode_manual_volt; // RULE9
  assign pump_offset_trim = state.regs[slot_pump];
  assign core_select  = state.core_out;
  assign band_select  = state.band_out;
  assign cal_readback = state.readback;

endmodule : vco_autocal_control_regs

`default_nettype wire

// [tb/vco_autocal_control_regs_properties.sv]
`default_nettype none
module vco_autocal_checker
  import vco_autocal_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [addr_w-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [3:0]        cal_core,
  input wire logic [7:0]        cal_band,
  input wire logic              level_ctl_off,
  input wire logic [9:0]        cal_timeout,
  input wire logic              adc_input_select,
  input wire logic              adc_enable,
  input wire logic              adc_convert,
  input wire logic              adc_quick_convert,
  input wire logic              adc_repeat_convert,
  input wire logic              adc_clk_tick,
  input wire logic [4:0]        lock_wait_limit,
  input wire logic [2:0]        cal_test_mode,
  input wire logic              manual_core_band_mode,
  input wire logic              manual_voltage_mode,
  input wire logic [3:0]        core_select,
  input wire logic [7:0]        band_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write data two edges back, the moment its register reaches the outputs.
  logic [7:0] wd1;
  logic [7:0] wd2;
  always_ff @(posedge aclk) begin
    wd1 <= s_axi_wdata[7:0];
    wd2 <= wd1;
  end
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_at(logic [addr_w-1:0] a);
    both_taken ##0 (s_axi_wstrb[0] && s_axi_awaddr == a);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_LEVEL: assert property (
    wr_at(12'h0b0) |-> ##2 level_ctl_off == wd2[0]) else $error("level bit");
  AST_TLOW: assert property (
    wr_at(12'h0c4) |-> ##2 cal_timeout[7:0] == wd2) else $error("timeout low");
  AST_ADCCTL: assert property (
    wr_at(12'h0c8) |-> ##2 {adc_input_select, adc_quick_convert,
    adc_repeat_convert, adc_convert, adc_enable, cal_timeout[9:8]}
    == {wd2[7], wd2[5:0]}) else $error("adc control fields");
  AST_LOCK: assert property (
    wr_at(12'h0cc) |-> ##2 lock_wait_limit == wd2[4:0]) else $error("lock");
  AST_TMODE: assert property (
    wr_at(12'h0d0) |-> ##2 cal_test_mode == wd2[7:5]) else $error("mode");
  AST_MODE: assert property (
    manual_core_band_mode == (cal_test_mode == mode_manual_core)
    && manual_voltage_mode == (cal_test_mode == mode_manual_volt))
    else $error("mode decode");
  AST_CAL: assert property (
    !manual_core_band_mode |=> core_select == $past(cal_core)
    && band_select == $past(cal_band)) else $error("calibrated core band");
  AST_ADC_IDLE: assert property (
    !adc_enable [*3] |-> !adc_clk_tick) else $error("adc tick while off");
  AST_BVALID: assert property (
    both_taken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("bvalid");
endmodule : vco_autocal_checker

bind vco_autocal_control_regs vco_autocal_checker u_checker (.*);
`default_nettype wire

// [tb/vco_autocal_control_regs_bench.sv]
`default_nettype none
module vco_autocal_control_regs_bench
  import vco_autocal_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [1:0]  r;
  } row_t;
  // Distinct values in every register but level and ADC divider (both 01) expose crossed address decodes.
  localparam row_t rows [11] = '{
    '{12'h0b0, 8'h01, resp_okay}, '{12'h0c0, 8'h03, resp_okay},
    '{12'h0c4, 8'ha5, resp_okay}, '{12'h0c8, 8'hbf, resp_okay},
    '{12'h0cc, 8'h35, resp_okay}, '{12'h0d0, 8'h40, resp_okay},
    '{12'h0d4, 8'h01, resp_okay}, '{12'h0d8, 8'h30, resp_okay},
    '{12'h0dc, 8'h5a, resp_okay}, '{12'h0e0, 8'hc3, resp_okay},
    '{12'h0b4, 8'hff, resp_slverr}};
  logic              aclk, aresetn, phase_detector_tick, level_ctl_off;
  logic [addr_w-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot, cal_test_mode;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]        s_axi_wstrb, cal_core, core_select;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, band_clk_tick, adc_clk_tick;
  logic [7:0]        cal_band, adc_result, pump_offset_trim, band_select;
  logic [9:0]        cal_timeout;
  logic              adc_input_select, adc_enable, adc_convert;
  logic              adc_quick_convert, adc_repeat_convert;
  logic              manual_core_band_mode, manual_voltage_mode;
  logic [4:0]        lock_wait_limit, level_wait_limit;
  logic [15:0]       cal_readback;
  int                n_fail = 0;
  int                num_checks = 0;
  int                nb, nc;

  vco_autocal_control_regs dut (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Handshakes are sampled mid-cycle, where they hold up to the next edge.
  task automatic wr(input row_t w, input logic s);
    logic ta, tw, tb;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr <= w.a;
    s_axi_wdata <= {24'h0, w.d};
    s_axi_wstrb <= {3'b000, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(br === w.r, "write response");
  endtask : wr

  task automatic rchk(input row_t w, input logic [7:0] e);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= w.a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(rsp === w.r && rdv === {24'h0, e}, "read back");
  endtask : rchk

  task automatic reset_state();
    foreach (rows[i]) rchk(rows[i], 8'h00);
    // Outputs are looked at mid-cycle, away from the edge that moves them.
    @(negedge aclk);
    chk({level_ctl_off, cal_timeout, adc_enable, lock_wait_limit,
         cal_test_mode, pump_offset_trim, adc_clk_tick} === '0, "reset");
    chk({core_select, band_select} === {cal_core, cal_band},
        "normal mode");
    chk(cal_readback === checker_pattern, "reset readback");
  endtask : reset_state

  task automatic pulses(input int n);
    nb = 0;
    nc = 0;
    @(posedge aclk);
    phase_detector_tick <= 1'b1;
    for (int i = 0; i < n + 4; i++) begin
      @(negedge aclk);
      nb += band_clk_tick;
      nc += adc_clk_tick;
      @(posedge aclk);
      if (i == n - 1) phase_detector_tick <= 1'b0;
    end
  endtask : pulses
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, phase_detector_tick, s_axi_awaddr, s_axi_araddr, s_axi_awprot,
     s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_wdata, s_axi_wstrb,
     s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    cal_core = 4'h6;
    cal_band = 8'h21;
    adc_result = 8'h9c;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    reset_state();
    foreach (rows[i]) begin
      wr(rows[i], 1'b1);
      rchk(rows[i], rows[i].r === resp_okay ? rows[i].d : 8'h00);
    end
    @(negedge aclk);
    chk(level_ctl_off === 1'b1, "level");
    chk(cal_timeout === 10'h3a5, "timeout");
    chk({adc_input_select, adc_quick_convert, adc_repeat_convert, adc_convert,
         adc_enable} === 5'h1f, "adc");
    chk(lock_wait_limit === 5'h15, "lock");
    chk(manual_core_band_mode === 1'b1 && cal_test_mode === 3'b010,
        "manual mode");
    chk(pump_offset_trim === 8'h30, "trim");
    chk(level_wait_limit === 5'h00, "level wait");
    chk({core_select, band_select} === 12'hc5a, "manual");
    chk(cal_readback === 16'h0c5a, "core band readback");
    pulses(12);
    chk(nb === 4, "band ticks");
    chk(nc === 2, "adc ticks");
    wr('{12'h0cc, 8'ha0, resp_okay}, 1'b1);
    @(negedge aclk);
    chk(cal_readback === 16'h009c, "adc readback");
    wr('{12'h0cc, 8'h40, resp_okay}, 1'b1);
    @(negedge aclk);
    chk(cal_readback === 16'h0000, "unused readback");
    wr('{12'h0d0, 8'h80, resp_okay}, 1'b1);
    @(negedge aclk);
    chk(manual_voltage_mode === 1'b1 && manual_core_band_mode === 1'b0,
        "voltage mode");
    chk({core_select, band_select} === 12'h621, "cal core");
    wr('{12'h0dc, 8'hff, resp_okay}, 1'b0);
    rchk('{12'h0dc, 8'h00, resp_okay}, 8'h5a);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    reset_state();
    // A zero divider and a powered-down ADC must both stay silent.
    pulses(12);
    chk(nb === 0 && nc === 0, "ticks while off");
    test_done();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    test_done();
  end
endmodule : vco_autocal_control_regs_bench
`default_nettype wire
